// ==== inc/hrp_pkg.sv ====
// Purpose: shared constants and types for the host register port
// Assumes: both ends run on a 50 MHz clk_sys
// Notes: serial frame is rw bit, 13 address bits, B bit, 8 data bits
`default_nettype none

package hrp_pkg;
   // clock and bus widths
   localparam int CLK_PERIOD_NS = 20;
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   // register file held by the device end
   localparam int REG_DEPTH = 16;
   localparam int REG_IDX_W = 4;
   localparam logic [7:0] REG_RESET = 8'h00;
   // roles of the shared data lines in serial mode
   localparam int BIT_POL = 7;
   localparam int BIT_PHA = 6;
   localparam int BIT_SWAP = 5;
   localparam int BIT_SCLK = 2;
   localparam int BIT_MOSI = 1;
   localparam int BIT_MISO = 0;
   localparam logic [7:0] SER_HOST_OE = 8'hE6;
   localparam logic [7:0] SER_DEV_OE = 8'h01;
   localparam logic [7:0] PAR_OE = 8'hFF;
   // serial frame layout, positions in order of transfer
   localparam logic [4:0] POS_RW = 5'h00;
   localparam logic [4:0] POS_ADDR = 5'h01;
   localparam logic [4:0] POS_B = 5'h0E;
   localparam logic [4:0] POS_DATA = 5'h0F;
   localparam logic [4:0] FRAME_BITS = 5'h17;
   localparam logic [5:0] FRAME_EDGES = 6'h2E;
   // pin bundle seen by the device: addr, data, cs, rd, wr, bus type, serial select
   localparam int PIN_W = ADDR_W + DATA_W + 5;
   localparam logic [PIN_W-1:0] PIN_RESET = {{(ADDR_W + DATA_W){1'b0}}, 5'h1C};
   // host strobe timing
   localparam int SETUP_NS = 80;
   localparam int STROBE_NS = 160;
   localparam int HOLD_NS = 80;
   localparam int SCLK_HALF_NS = 160;
   localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_SETUP = 3'h1,
      S_ACT = 3'h3,
      S_HOLD = 3'h2,
      S_SHIFT = 3'h6
   } host_state_t;
endpackage

`default_nettype wire

// ==== inc/host_port_if.sv ====
// Purpose: pins between the host and the device register port
// Assumes: each end drives data lines only through its own enables
// Notes: undriven data lines resolve low, standing in for pulldowns
`default_nettype none

interface host_port_if;
   import hrp_pkg::*;
   logic [ADDR_W-1:0] addr;
   logic chip_select_n;
   logic read_strobe_n;
   logic write_strobe_n;
   logic bus_type_select;
   logic serial_select;
   logic [DATA_W-1:0] host_d_out;
   logic [DATA_W-1:0] host_d_oe;
   logic [DATA_W-1:0] dev_d_out;
   logic [DATA_W-1:0] dev_d_oe;
   logic [DATA_W-1:0] data_bus;

   // wire level per line; device drive wins if both collide
   always_comb begin
      for (int i = 0; i < DATA_W; i++) begin
         if (dev_d_oe[i]) begin
            data_bus[i] = dev_d_out[i];
         end else if (host_d_oe[i]) begin
            data_bus[i] = host_d_out[i];
         end else begin
            data_bus[i] = 1'b0;
         end
      end
   end

   modport device (
      input addr, chip_select_n, read_strobe_n, write_strobe_n,
      input bus_type_select, serial_select, data_bus,
      output dev_d_out, dev_d_oe
   );
   modport host (
      output addr, chip_select_n, read_strobe_n, write_strobe_n,
      output bus_type_select, serial_select, host_d_out, host_d_oe,
      input data_bus
   );
endinterface

`default_nettype wire

// ==== logic/sync2.sv ====
// Purpose: two flip-flop synchroniser for a bundle of levels
// Assumes: each bit is a level; bits may skew by one cycle
// Notes: reset value lets idle-high strobes start inactive
`default_nettype none

module sync2 #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_r;

   // first stage feeds only the second
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= RESET_VAL;
         q <= RESET_VAL;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

`default_nettype wire

// ==== logic/host_port_device.sv ====
// Purpose: device end of the parallel/serial host register port
// Assumes: all pins are sampled by clk_sys through two flip-flops
// Notes: pin reactions lag the pins by about three clk_sys cycles
//
// Contract
// - 8-bit data bus carries writes and reads
// - data lines undriven while chip select high
// - line seven strap sets serial clock polarity
// - line six strap sets serial clock phase
// - polarity and phase default low
// - swap strap high reverses address, data order
// - swap zero LSB first, one MSB first
// - rw and B bits keep fixed positions
// - host drives serial clock on line two
// - host sends serial bits on line one
// - device returns serial read data, line zero
// - chip select qualifies every strobe
// - intel read drives while rd, cs low
// - motorola read: strobe, cs low, rw high
// - host presents 13-bit address, A12 MSB
// - write captured at strobe rising edge
// - serial select low parallel, high serial
// - bus type high motorola; low in serial
`default_nettype none

module host_port_device (
   input wire logic clk_sys,
   input wire logic rst_n,
   host_port_if.device bus,
   output logic wr_pulse,
   output logic [hrp_pkg::ADDR_W-1:0] wr_addr,
   output logic [hrp_pkg::DATA_W-1:0] wr_data,
   output logic serial_mode,
   output logic serial_clock_polarity_strap,
   output logic serial_clock_phase_strap,
   output logic bit_order_swap_strap
);
   import hrp_pkg::*;

   logic [PIN_W-1:0] pins_s;
   logic [ADDR_W-1:0] a_s;
   logic [DATA_W-1:0] d_s;
   logic cs_n_s;
   logic rs_n_s;
   logic ws_n_s;
   logic bts_s;
   logic ssel_s;

   logic cs_prev_r, cs_prev_nxt;
   logic rs_prev_r, rs_prev_nxt;
   logic ws_prev_r, ws_prev_nxt;
   logic sclk_prev_r, sclk_prev_nxt;
   logic pol_r, pol_nxt;
   logic pha_r, pha_nxt;
   logic swp_r, swp_nxt;
   logic ser_r, ser_nxt;
   logic [4:0] cnt_r, cnt_nxt;
   logic rw_r, rw_nxt;
   logic [ADDR_W-1:0] sa_r, sa_nxt;
   logic [DATA_W-1:0] sd_r, sd_nxt;
   logic [DATA_W-1:0] rbuf_r, rbuf_nxt;
   logic miso_r, miso_nxt;
   logic [DATA_W-1:0] regs_r [REG_DEPTH];
   logic [DATA_W-1:0] regs_nxt [REG_DEPTH];
   logic [DATA_W-1:0] oe_r, oe_nxt;
   logic [DATA_W-1:0] out_r, out_nxt;
   logic wr_pulse_nxt;
   logic [ADDR_W-1:0] wr_addr_nxt;
   logic [DATA_W-1:0] wr_data_nxt;

   logic wen;
   logic [ADDR_W-1:0] wa;
   logic [DATA_W-1:0] wd;
   logic [ADDR_W-1:0] rd_a;
   logic [DATA_W-1:0] rdat;
   logic sclk;
   logic samp;
   logic shft;
   logic mbit;
   logic [3:0] ai;
   logic [2:0] di;

   // every pin crosses into clk_sys before any logic looks at it
   sync2 #(.WIDTH(PIN_W), .RESET_VAL(PIN_RESET)) u_pin_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .d({bus.addr, bus.data_bus, bus.chip_select_n, bus.read_strobe_n,
          bus.write_strobe_n, bus.bus_type_select, bus.serial_select}),
      .q(pins_s)
   );

   assign {a_s, d_s, cs_n_s, rs_n_s, ws_n_s, bts_s, ssel_s} = pins_s;
   assign bus.dev_d_out = out_r;
   assign bus.dev_d_oe = oe_r;

   // register read mux; serial uses the shifted-in address
   always_comb begin
      rd_a = ssel_s ? sa_r : a_s;
      rdat = '0;
      if (rd_a < ADDR_W'(REG_DEPTH)) begin
         rdat = regs_r[rd_a[REG_IDX_W-1:0]];
      end
   end

   // next state of the whole port
   always_comb begin
      cs_prev_nxt = cs_n_s;
      rs_prev_nxt = rs_n_s;
      ws_prev_nxt = ws_n_s;
      sclk_prev_nxt = d_s[BIT_SCLK];
      pol_nxt = pol_r;
      pha_nxt = pha_r;
      swp_nxt = swp_r;
      ser_nxt = ssel_s;
      cnt_nxt = cnt_r;
      rw_nxt = rw_r;
      sa_nxt = sa_r;
      sd_nxt = sd_r;
      rbuf_nxt = rbuf_r;
      miso_nxt = miso_r;
      regs_nxt = regs_r;
      wen = 1'b0;
      wa = a_s;
      wd = d_s;
      ai = '0;
      di = '0;
      mbit = d_s[BIT_MOSI];
      sclk = d_s[BIT_SCLK];
      // sample edge is the leading one when phase is low
      samp = (pol_r == pha_r) ? (sclk && !sclk_prev_r) : (!sclk && sclk_prev_r);
      shft = (pol_r == pha_r) ? (!sclk && sclk_prev_r) : (sclk && !sclk_prev_r);

      // parallel writes, gated by chip select
      if (!ssel_s && !cs_n_s) begin
         if (!bts_s && ws_n_s && !ws_prev_r) begin
            wen = 1'b1;
         end
         if (bts_s && rs_n_s && !rs_prev_r && !ws_n_s) begin
            wen = 1'b1;
         end
      end

      // in serial mode only, straps are caught as chip select falls, then frozen for the frame
      if (ssel_s && cs_prev_r && !cs_n_s) begin
         pol_nxt = d_s[BIT_POL];
         pha_nxt = d_s[BIT_PHA];
         swp_nxt = d_s[BIT_SWAP];
         cnt_nxt = '0;
      end else if (ssel_s && !cs_n_s) begin
         if (samp && (cnt_r < FRAME_BITS)) begin
            cnt_nxt = cnt_r + 5'h01;
            if (cnt_r == POS_RW) begin
               rw_nxt = mbit;
            end else if (cnt_r < POS_B) begin
               ai = 4'(cnt_r - POS_ADDR);
               if (swp_r) begin
                  ai = 4'(ADDR_W - 1) - ai;
               end
               sa_nxt[ai] = mbit;
            end else if (cnt_r == POS_B) begin
               // B bit position is fixed; its value is not used here
               rbuf_nxt = rdat;
            end else begin
               di = 3'(cnt_r - POS_DATA);
               if (swp_r) begin
                  di = 3'(DATA_W - 1) - di;
               end
               sd_nxt[di] = mbit;
               if ((cnt_r == FRAME_BITS - 5'h01) && !rw_r) begin
                  wen = 1'b1;
                  wa = sa_r;
                  wd = sd_nxt;
               end
            end
         end
         // read bits leave on the edge before the host samples them
         if (shft && (cnt_r >= POS_DATA) && (cnt_r < FRAME_BITS)) begin
            di = 3'(cnt_r - POS_DATA);
            if (swp_r) begin
               di = 3'(DATA_W - 1) - di;
            end
            miso_nxt = rbuf_r[di];
         end
      end

      // register file and write report
      if (wen && (wa < ADDR_W'(REG_DEPTH))) begin
         regs_nxt[wa[REG_IDX_W-1:0]] = wd;
      end
      wr_pulse_nxt = wen;
      wr_addr_nxt = wen ? wa : wr_addr;
      wr_data_nxt = wen ? wd : wr_data;

      // data line drive: nothing unless chip select is low
      oe_nxt = '0;
      out_nxt = '0;
      if (!ssel_s && !cs_n_s && !rs_n_s && (!bts_s || ws_n_s)) begin
         oe_nxt = PAR_OE;
         out_nxt = rdat;
      end else if (ssel_s && !cs_n_s) begin
         oe_nxt = SER_DEV_OE;
         out_nxt[BIT_MISO] = miso_r;
      end
   end

   // registers only
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cs_prev_r <= 1'b1;
         rs_prev_r <= 1'b1;
         ws_prev_r <= 1'b1;
         sclk_prev_r <= 1'b0;
         pol_r <= 1'b0;
         pha_r <= 1'b0;
         swp_r <= 1'b0;
         ser_r <= 1'b0;
         cnt_r <= '0;
         rw_r <= 1'b0;
         sa_r <= '0;
         sd_r <= '0;
         rbuf_r <= '0;
         miso_r <= 1'b0;
         for (int i = 0; i < REG_DEPTH; i++) begin
            regs_r[i] <= REG_RESET;
         end
         oe_r <= '0;
         out_r <= '0;
         wr_pulse <= 1'b0;
         wr_addr <= '0;
         wr_data <= '0;
      end else begin
         cs_prev_r <= cs_prev_nxt;
         rs_prev_r <= rs_prev_nxt;
         ws_prev_r <= ws_prev_nxt;
         sclk_prev_r <= sclk_prev_nxt;
         pol_r <= pol_nxt;
         pha_r <= pha_nxt;
         swp_r <= swp_nxt;
         ser_r <= ser_nxt;
         cnt_r <= cnt_nxt;
         rw_r <= rw_nxt;
         sa_r <= sa_nxt;
         sd_r <= sd_nxt;
         rbuf_r <= rbuf_nxt;
         miso_r <= miso_nxt;
         regs_r <= regs_nxt;
         oe_r <= oe_nxt;
         out_r <= out_nxt;
         wr_pulse <= wr_pulse_nxt;
         wr_addr <= wr_addr_nxt;
         wr_data <= wr_data_nxt;
      end
   end

   // strap and mode view for the user side
   assign serial_mode = ser_r;
   assign serial_clock_polarity_strap = pol_r;
   assign serial_clock_phase_strap = pha_r;
   assign bit_order_swap_strap = swp_r;
endmodule

`default_nettype wire

// ==== logic/host_port_host.sv ====
// Purpose: host end that runs register accesses over the port pins
// Assumes: cfg inputs stay stable while busy is high
// Notes: serial clock is made here by a divider, half period SCLK_HALF_CYC
`default_nettype none

module host_port_host (
   input wire logic clk_sys,
   input wire logic rst_n,
   host_port_if.host bus,
   input wire logic req,
   input wire logic req_read,
   input wire logic [hrp_pkg::ADDR_W-1:0] req_addr,
   input wire logic [hrp_pkg::DATA_W-1:0] req_wdata,
   input wire logic cfg_serial,
   input wire logic cfg_motorola,
   input wire logic cfg_polarity,
   input wire logic cfg_phase,
   input wire logic cfg_swap,
   output logic busy,
   output logic done,
   output logic [hrp_pkg::DATA_W-1:0] rdata
);
   import hrp_pkg::*;

   host_state_t st_r, st_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [5:0] ec_r, ec_nxt;
   logic sclk_r, sclk_nxt;
   logic op_rd_r, op_rd_nxt;
   logic [ADDR_W-1:0] addr_r, addr_nxt;
   logic [DATA_W-1:0] data_r, data_nxt;
   logic [DATA_W-1:0] rx_r, rx_nxt;
   logic cs_r, cs_nxt;
   logic rs_r, rs_nxt;
   logic ws_r, ws_nxt;
   logic bts_r, bts_nxt;
   logic ssel_r, ssel_nxt;
   logic [DATA_W-1:0] hout_r, hout_nxt;
   logic [DATA_W-1:0] hoe_r, hoe_nxt;
   logic busy_nxt, done_nxt;
   logic [DATA_W-1:0] rdata_nxt;
   logic [DATA_W-1:0] d_s;
   logic [22:0] seq;
   logic [5:0] k;
   logic [2:0] j;

   sync2 #(.WIDTH(DATA_W), .RESET_VAL('0)) u_data_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .d(bus.data_bus),
      .q(d_s)
   );

   assign bus.addr = addr_r;
   assign bus.chip_select_n = cs_r;
   assign bus.read_strobe_n = rs_r;
   assign bus.write_strobe_n = ws_r;
   assign bus.bus_type_select = bts_r;
   assign bus.serial_select = ssel_r;
   assign bus.host_d_out = hout_r;
   assign bus.host_d_oe = hoe_r;

   // sequencer for parallel strobes and serial frames
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r + 4'h1;
      ec_nxt = ec_r;
      sclk_nxt = sclk_r;
      op_rd_nxt = op_rd_r;
      addr_nxt = addr_r;
      data_nxt = data_r;
      rx_nxt = rx_r;
      cs_nxt = cs_r;
      rs_nxt = rs_r;
      ws_nxt = ws_r;
      bts_nxt = bts_r;
      ssel_nxt = ssel_r;
      hout_nxt = hout_r;
      hoe_nxt = hoe_r;
      busy_nxt = busy;
      done_nxt = 1'b0;
      rdata_nxt = rdata;
      seq = '0;
      k = '0;
      j = '0;
      case (st_r)
         S_IDLE: begin
            cs_nxt = 1'b1;
            rs_nxt = 1'b1;
            ws_nxt = 1'b1;
            ssel_nxt = cfg_serial;
            bts_nxt = cfg_motorola && !cfg_serial;
            sclk_nxt = cfg_polarity;
            hoe_nxt = cfg_serial ? SER_HOST_OE : '0;
            hout_nxt = '0;
            hout_nxt[BIT_POL] = cfg_polarity;
            hout_nxt[BIT_PHA] = cfg_phase;
            hout_nxt[BIT_SWAP] = cfg_swap;
            hout_nxt[BIT_SCLK] = cfg_polarity;
            if (req) begin
               op_rd_nxt = req_read;
               addr_nxt = req_addr;
               data_nxt = req_wdata;
               busy_nxt = 1'b1;
               cs_nxt = 1'b0;
               cnt_nxt = '0;
               ec_nxt = '0;
               if (cfg_serial) begin
                  st_nxt = S_SHIFT;
               end else begin
                  st_nxt = S_SETUP;
                  ws_nxt = cfg_motorola ? req_read : 1'b1;
                  if (!req_read) begin
                     hoe_nxt = PAR_OE;
                     hout_nxt = req_wdata;
                  end
               end
            end
         end
         S_SETUP: begin
            if (cnt_r == 4'(SETUP_CYC - 1)) begin
               st_nxt = S_ACT;
               cnt_nxt = '0;
               if (cfg_motorola || op_rd_r) begin
                  rs_nxt = 1'b0;
               end else begin
                  ws_nxt = 1'b0;
               end
            end
         end
         S_ACT: begin
            if (cnt_r == 4'(STROBE_CYC - 1)) begin
               st_nxt = S_HOLD;
               cnt_nxt = '0;
               rs_nxt = 1'b1;
               ws_nxt = cfg_motorola ? ws_r : 1'b1;
               if (op_rd_r) begin
                  rx_nxt = d_s;
               end
            end
         end
         S_HOLD: begin
            if (cnt_r == 4'(HOLD_CYC - 1)) begin
               st_nxt = S_IDLE;
               cs_nxt = 1'b1;
               ws_nxt = 1'b1;
               if (!cfg_serial) begin
                  hoe_nxt = '0;
               end
               busy_nxt = 1'b0;
               done_nxt = 1'b1;
               if (op_rd_r) begin
                  rdata_nxt = rx_r;
               end
            end
         end
         S_SHIFT: begin
            if (cnt_r == 4'(SCLK_HALF_CYC - 1)) begin
               cnt_nxt = '0;
               if (ec_r == FRAME_EDGES) begin
                  st_nxt = S_HOLD;
               end else begin
                  ec_nxt = ec_r + 6'h01;
                  sclk_nxt = !sclk_r;
                  // sample edges are odd when phase is low, even when high
                  if (ec_nxt[0] != cfg_phase) begin
                     k = (ec_r - {5'h00, cfg_phase}) >> 1;
                     if (k >= {1'b0, POS_DATA}) begin
                        j = 3'(k - {1'b0, POS_DATA});
                        if (cfg_swap) begin
                           j = 3'(DATA_W - 1) - j;
                        end
                        rx_nxt[j] = d_s[BIT_MISO];
                     end
                  end
               end
            end
         end
         default: begin
            st_nxt = S_IDLE;
         end
      endcase

      // frame bits in transfer order; rw and B never move
      seq[POS_RW] = op_rd_nxt;
      for (int i = 0; i < ADDR_W; i++) begin
         seq[POS_ADDR + 5'(i)] = addr_nxt[cfg_swap ? ADDR_W - 1 - i : i];
      end
      seq[POS_B] = 1'b0;
      for (int i = 0; i < DATA_W; i++) begin
         seq[POS_DATA + 5'(i)] = data_nxt[cfg_swap ? DATA_W - 1 - i : i];
      end
      // mosi changes only on shift edges, so it is a function of edge count
      if (st_nxt == S_SHIFT) begin
         k = (ec_nxt < {5'h00, cfg_phase}) ? 6'h00 : ((ec_nxt - {5'h00, cfg_phase}) >> 1);
         if (k > {1'b0, FRAME_BITS - 5'h01}) begin
            k = {1'b0, FRAME_BITS - 5'h01};
         end
         hout_nxt[BIT_SCLK] = sclk_nxt;
         hout_nxt[BIT_MOSI] = seq[k[4:0]];
      end
   end

   // registers only
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= S_IDLE;
         cnt_r <= '0;
         ec_r <= '0;
         sclk_r <= 1'b0;
         op_rd_r <= 1'b0;
         addr_r <= '0;
         data_r <= '0;
         rx_r <= '0;
         cs_r <= 1'b1;
         rs_r <= 1'b1;
         ws_r <= 1'b1;
         bts_r <= 1'b0;
         ssel_r <= 1'b0;
         hout_r <= '0;
         hoe_r <= '0;
         busy <= 1'b0;
         done <= 1'b0;
         rdata <= '0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         ec_r <= ec_nxt;
         sclk_r <= sclk_nxt;
         op_rd_r <= op_rd_nxt;
         addr_r <= addr_nxt;
         data_r <= data_nxt;
         rx_r <= rx_nxt;
         cs_r <= cs_nxt;
         rs_r <= rs_nxt;
         ws_r <= ws_nxt;
         bts_r <= bts_nxt;
         ssel_r <= ssel_nxt;
         hout_r <= hout_nxt;
         hoe_r <= hoe_nxt;
         busy <= busy_nxt;
         done <= done_nxt;
         rdata <= rdata_nxt;
      end
   end
endmodule

`default_nettype wire

// ==== dv/host_register_port_monitor.sv ====
// Purpose: pin checks on the link between the host end and the device end
// Assumes: the device reacts within three clk_sys cycles of a pin change
// Notes: five-cycle windows leave room for the device's synchroniser lag
`default_nettype none

module host_register_port_monitor (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic chip_select_n,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic bus_type_select,
   input wire logic serial_select,
   input wire logic [hrp_pkg::DATA_W-1:0] host_d_out,
   input wire logic [hrp_pkg::DATA_W-1:0] host_d_oe,
   input wire logic [hrp_pkg::DATA_W-1:0] dev_d_oe
);
   import hrp_pkg::*;
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   // read qualifiers held long enough to pass the sync flops
   sequence s_intel_rd;
      (!chip_select_n && !read_strobe_n && !bus_type_select && !serial_select) [*5];
   endsequence
   sequence s_moto_rd;
      (!chip_select_n && !read_strobe_n && write_strobe_n && bus_type_select
         && !serial_select) [*5];
   endsequence
   property p_cs_quiet;
      chip_select_n [*5] |-> dev_d_oe == 8'h00;
   endproperty
   property p_intel_rd;
      s_intel_rd |-> dev_d_oe == PAR_OE;
   endproperty
   property p_moto_rd;
      s_moto_rd |-> dev_d_oe == PAR_OE;
   endproperty
   property p_miso;
      (!chip_select_n && serial_select) [*5] |-> dev_d_oe == SER_DEV_OE;
   endproperty
   property p_no_rd;
      (read_strobe_n && !serial_select) [*5] |-> dev_d_oe == 8'h00;
   endproperty
   property p_one_driver;
      (host_d_oe & dev_d_oe) == 8'h00;
   endproperty
   property p_ser_lines;
      serial_select && !chip_select_n |-> host_d_oe == SER_HOST_OE && !bus_type_select;
   endproperty
   property p_sclk_idle;
      $fell(chip_select_n) && serial_select |-> host_d_out[BIT_SCLK] == host_d_out[BIT_POL];
   endproperty
   a_cs_quiet: assert property (p_cs_quiet) else $error("bus driven while deselected");
   a_intel_rd: assert property (p_intel_rd) else $error("intel read not driven");
   a_moto_rd: assert property (p_moto_rd) else $error("motorola read not driven");
   a_miso: assert property (p_miso) else $error("serial return line wrong");
   a_no_rd: assert property (p_no_rd) else $error("drive without read strobe");
   a_one_driver: assert property (p_one_driver) else $error("both ends drive a line");
   a_ser_lines: assert property (p_ser_lines) else $error("serial host lines wrong");
   a_sclk_idle: assert property (p_sclk_idle) else $error("clock idle not polarity");
endmodule

`default_nettype wire

// ==== dv/host_register_port_tb_top.sv ====
// Purpose: self-checking bench joining the host end to the device end
// Assumes: one access at a time through the host end
// Notes: serial rows run last, since the straps keep their serial values after a frame
`default_nettype none

module host_register_port_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import hrp_pkg::*;
   typedef struct packed {
      logic [4:0] cfg;
      logic rd;
      logic [12:0] a;
      logic [7:0] d;
   } row_t;
   row_t rows[26];
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic req = 1'b0;
   logic req_read = 1'b0;
   logic [ADDR_W-1:0] req_addr = '0;
   logic [DATA_W-1:0] req_wdata = '0;
   logic [4:0] cfg = 5'h00;
   logic busy, done, wr_pulse, serial_mode, pol_s, pha_s, swap_s;
   logic [DATA_W-1:0] rdata, wr_data;
   logic [ADDR_W-1:0] wr_addr;
   int fails = 0;
   int checks_done = 0;
   int wr_seen = 0;
   int n_wr;

   host_port_if bus_if ();
   host_port_host host_port_host_inst (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus_if.host),
      .req(req), .req_read(req_read), .req_addr(req_addr), .req_wdata(req_wdata),
      .cfg_serial(cfg[4]), .cfg_motorola(cfg[3]), .cfg_polarity(cfg[2]),
      .cfg_phase(cfg[1]), .cfg_swap(cfg[0]), .busy(busy), .done(done), .rdata(rdata));
   host_port_device host_port_device_inst (.clk_sys(clk_sys), .rst_n(rst_n),
      .bus(bus_if.device), .wr_pulse(wr_pulse), .wr_addr(wr_addr), .wr_data(wr_data),
      .serial_mode(serial_mode), .serial_clock_polarity_strap(pol_s),
      .serial_clock_phase_strap(pha_s), .bit_order_swap_strap(swap_s));
   host_register_port_monitor host_register_port_monitor_inst (.clk_sys(clk_sys),
      .rst_n(rst_n), .chip_select_n(bus_if.chip_select_n),
      .read_strobe_n(bus_if.read_strobe_n), .write_strobe_n(bus_if.write_strobe_n),
      .bus_type_select(bus_if.bus_type_select), .serial_select(bus_if.serial_select),
      .host_d_out(bus_if.host_d_out), .host_d_oe(bus_if.host_d_oe),
      .dev_d_oe(bus_if.dev_d_oe));

   // free-running system clock
   always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
   // count write pulses so a lost or doubled capture shows
   always @(posedge clk_sys) if (wr_pulse === 1'b1) wr_seen <= wr_seen + 1;

   task automatic wrap_up;
      if (fails == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_cnt(input int got, input int exp);
      chk(24'(got), 24'(exp));
   endtask
   task automatic chk_idle;
      // chip select sits at bit 11, above the eight enables and three straps
      chk({12'h000, bus_if.chip_select_n, bus_if.dev_d_oe, pol_s, pha_s, swap_s}, 24'h000800);
   endtask
   // one request, then wait at falling edges for done, bounded
   task automatic access(input row_t r);
      int n;
      n = 0;
      @(posedge clk_sys);
      cfg <= r.cfg;
      req <= 1'b1;
      req_read <= r.rd;
      req_addr <= r.a;
      req_wdata <= r.d;
      @(posedge clk_sys);
      req <= 1'b0;
      while (done !== 1'b1 && n < 1000) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 1000) begin
         fails++;
         wrap_up();
      end
   endtask

   initial begin
      // intel and motorola rows, then every serial strap combination
      rows[0] = {5'h00, 1'b0, 13'h0003, 8'hA5};
      rows[1] = {5'h00, 1'b1, 13'h0003, 8'hA5};
      rows[2] = {5'h08, 1'b0, 13'h000F, 8'h3C};
      rows[3] = {5'h08, 1'b1, 13'h000F, 8'h3C};
      rows[4] = {5'h00, 1'b0, 13'h1003, 8'h77};
      rows[5] = {5'h08, 1'b1, 13'h0003, 8'hA5};
      rows[6] = {5'h00, 1'b1, 13'h0010, 8'h00};
      rows[7] = {5'h00, 1'b1, 13'h1FFF, 8'h00};
      rows[8] = {5'h08, 1'b0, 13'h0000, 8'hFF};
      rows[9] = {5'h00, 1'b1, 13'h0000, 8'hFF};
      for (int i = 0; i < 8; i++) begin
         rows[10 + 2 * i] = {2'b10, i[2:0], 1'b0, 13'(4 + i), 8'h96 + 8'(i)};
         rows[11 + 2 * i] = {2'b10, i[2:0], 1'b1, 13'(4 + i), 8'h96 + 8'(i)};
      end
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(negedge clk_sys);
      chk_idle();
      foreach (rows[k]) begin
         n_wr = wr_seen;
         access(rows[k]);
         if (rows[k].rd) begin
            chk({16'h0000, rdata}, {16'h0000, rows[k].d});
         end else if (rows[k].a < 13'h0010) begin
            chk({3'h0, wr_addr, wr_data}, {3'h0, rows[k].a, rows[k].d});
         end
         if (rows[k].rd || rows[k].a < 13'h0010) begin
            chk_cnt(wr_seen - n_wr, rows[k].rd ? 0 : 1);
         end
         chk({19'h00000, busy, serial_mode, pol_s, pha_s, swap_s},
             {19'h00000, 1'b0, rows[k].cfg[4], rows[k].cfg[2:0]});
      end
      // reset in mid-write: registers clear and straps fall back low
      repeat (6) @(posedge clk_sys);
      fork
         access({5'h00, 1'b0, 13'h0004, 8'hEE});
      join_none
      repeat (12) @(posedge clk_sys);
      disable fork;
      rst_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(negedge clk_sys);
      chk_idle();
      access({5'h00, 1'b1, 13'h0004, 8'h00});
      chk({16'h0000, rdata}, 24'h000000);
      wrap_up();
   end
endmodule

`default_nettype wire
